/* File: rtl/aem_pkg.sv */
package aem_pkg;

  // ==========================================================================
  // Host register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_RX_FLAGS    = 8'h02;
  localparam logic [7:0]  ADDR_UPD_FLAGS   = 8'h03;
  localparam logic [7:0]  ADDR_FORMAT      = 8'h04;
  localparam logic [7:0]  ADDR_FILTER_BASE = 8'h0A;
  localparam int          NUM_FILTERS      = 5;
  localparam logic [15:0] REG_RESET        = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          FMT_UPDATE_BIT   = 11;
  localparam int          FMT_AP_VALID_BIT = 10;
  localparam int          FMT_FF_VALID_BIT = 9;
  localparam int          FMT_PRESENT_BIT  = 8;
  localparam int          FLAG_ANC_LSB     = 10;
  localparam int          FLAG_FF_LSB      = 5;
  localparam int          FLAG_AP_LSB      = 0;
  localparam int          FLAG_WIDTH       = 15;
  localparam logic [14:0] UES_MASK         = 15'h4210;
  localparam int          FILT_DID_LSB     = 8;
  localparam logic [7:0]  ID_WILDCARD      = 8'h00;

  // ==========================================================================
  // Ancillary packet framing
  // ==========================================================================
  localparam logic [7:0]  PRE_ZERO_HI      = 8'h00;
  localparam logic [7:0]  PRE_ONES_HI      = 8'hFF;
  localparam logic [7:0]  EDH_DID          = 8'hF4;
  localparam logic [8:0]  HDR_WORDS        = 9'h007;
  localparam int          DLY_DEPTH        = 5;
  localparam logic [8:0]  POS_DID          = 9'h003;
  localparam logic [8:0]  POS_ANC_FLAGS    = 9'h00C;
  localparam logic [8:0]  POS_AP_FLAGS     = 9'h00D;
  localparam logic [8:0]  POS_FF_FLAGS     = 9'h00E;
  localparam logic [7:0]  UDW_AP_CRC_HI    = 8'h02;
  localparam logic [7:0]  UDW_FF_CRC_HI    = 8'h05;
  localparam logic [7:0]  UDW_ANC_FLAGS    = 8'h06;
  localparam logic [7:0]  UDW_AP_FLAGS     = 8'h07;
  localparam logic [7:0]  UDW_FF_FLAGS     = 8'h08;
  localparam int          CRC_V_BIT        = 7;
  localparam int          WORD_FLAG_LSB    = 2;

  // ==========================================================================
  // Parser states
  // ==========================================================================
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PRE1 = 7'h02,
    ST_PRE2 = 7'h04,
    ST_DID  = 7'h08,
    ST_SDID = 7'h10,
    ST_DC   = 7'h20,
    ST_BODY = 7'h40
  } aem_state_e;

endpackage

/* File: rtl/aem_filter_match.sv */
module aem_filter_match (
  input  wire logic [4:0][15:0] filters,
  input  wire logic [7:0]       did,
  input  wire logic [7:0]       sdid,
  output logic                  hit,
  output logic                  any_set
);

  logic [4:0] set;
  logic [4:0] match;

  // ==========================================================================
  // Per-filter compare, zero fields act as wildcards in a filter that is not all zero
  // ==========================================================================
  for (genvar g = 0; g < aem_pkg::NUM_FILTERS; g++) begin : g_filt
    logic [7:0] f_did;
    logic [7:0] f_sdid;
    assign f_did    = filters[g][15:aem_pkg::FILT_DID_LSB];
    assign f_sdid   = filters[g][aem_pkg::FILT_DID_LSB-1:0];
    assign set[g]   = |filters[g];
    assign match[g] = set[g]
                    && (f_did == aem_pkg::ID_WILDCARD || f_did == did)
                    && (f_sdid == aem_pkg::ID_WILDCARD || f_sdid == sdid);
  end

  assign hit     = |match;
  assign any_set = |set;

endmodule

/* File: rtl/aem_monitor.sv */
module aem_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  rx_word,
  input  wire logic        rx_vblank,
  input  wire logic [9:0]  fifo_word,
  input  wire logic        fifo_vblank,
  input  wire logic        fifo_video_mode,
  input  wire logic        ap_crc_error,
  input  wire logic        ff_crc_error,
  input  wire logic        anc_checksum_error,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic [9:0]       vid_out,
  output logic             aux_presence,
  output logic             edh_packet_present
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    // Packet parser.
    aem_pkg::aem_state_e st;
    logic [7:0]          did;
    logic [7:0]          sdid;
    logic [8:0]          body_left;
    logic [7:0]          udw_idx;

    // Delay line, strobe and rewrite of the outgoing stream.
    logic [4:0][9:0]     dly;
    logic [8:0]          cnt;
    logic [8:0]          pos;
    logic                aux_sel;
    logic                ins_on;
    logic [8:0]          sum;
    logic [9:0]          out_word;
    logic                aux_out;

    // Host-visible registers and EDH status.
    logic [4:0][15:0]    filt;
    logic                upd_en;
    logic [14:0]         rx_flags;
    logic [14:0]         upd_flags;
    logic                ap_v;
    logic                ff_v;
    logic                present;
    logic                seen_vb;
    logic                v_q;
    logic [15:0]         rdata;
  } aem_state_s;

  aem_state_s s_q;
  aem_state_s s_d;

  logic        filt_hit;
  logic        filt_any;
  logic [9:0]  in_word;
  logic        in_v;

  // ==========================================================================
  // Filter compare
  // ==========================================================================
  aem_filter_match u_match (
    .filters (s_q.filt),
    .did     (s_q.did),
    .sdid    (s_q.sdid),
    .hit     (filt_hit),
    .any_set (filt_any)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [4:0] upd_group(input logic [4:0] f, input logic err);
    // Field order is ues, ida, idh, eda, edh from the top bit down.
    logic unsupported_marker;
    logic ida;
    logic eda;
    unsupported_marker       = f[4];
    ida       = f[3] | f[2];
    eda       = f[1] | f[0];
    upd_group = {unsupported_marker, ida, 1'b0, eda, err};
  endfunction

  function automatic logic [9:0] flag_word(input logic [4:0] f);
    // Bit 9 is the inverse of the parity bit, keeping the word clear of reserved codes.
    logic [7:0] b;
    b = {1'b0, f, 2'b00};
    flag_word = {~(^b), ^b, b};
  endfunction

  // Updated flags as they would be stored now, from stored flags and live error inputs.
  logic [14:0] upd_now;

  always_comb begin
    upd_now = {upd_group(s_q.rx_flags[14:10], anc_checksum_error),
               upd_group(s_q.rx_flags[9:5], ff_crc_error),
               upd_group(s_q.rx_flags[4:0], ap_crc_error)};
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic        start;
  logic        emitting;
  logic        last;
  logic [8:0]  emit_pos;
  logic [9:0]  w;
  logic        pkt_end;
  logic        v_fall;
  logic [7:0]  dc;

  always_comb begin
    s_d      = s_q;
    in_word  = fifo_video_mode ? fifo_word : rx_word;
    in_v     = fifo_video_mode ? fifo_vblank : rx_vblank;
    dc       = in_word[7:0];
    start    = 1'b0;
    pkt_end  = 1'b0;
    v_fall   = s_q.v_q && !in_v;
    s_d.v_q  = in_v;

    // ========================================================================
    // Input side: packet parser, running anywhere in the stream.
    // ========================================================================
    case (s_q.st)
      aem_pkg::ST_IDLE: begin
        if (in_word[9:2] == aem_pkg::PRE_ZERO_HI) begin
          s_d.st = aem_pkg::ST_PRE1;
        end
      end
      aem_pkg::ST_PRE1: begin
        if (in_word[9:2] == aem_pkg::PRE_ONES_HI) begin
          s_d.st = aem_pkg::ST_PRE2;
        end else if (in_word[9:2] != aem_pkg::PRE_ZERO_HI) begin
          s_d.st = aem_pkg::ST_IDLE;
        end
      end
      aem_pkg::ST_PRE2: begin
        if (in_word[9:2] == aem_pkg::PRE_ONES_HI) begin
          s_d.st = aem_pkg::ST_DID;
        end else if (in_word[9:2] == aem_pkg::PRE_ZERO_HI) begin
          // A zero word restarts the preamble search.
          s_d.st = aem_pkg::ST_PRE1;
        end else begin
          s_d.st = aem_pkg::ST_IDLE;
        end
      end
      aem_pkg::ST_DID: begin
        s_d.did = in_word[7:0];
        s_d.st  = aem_pkg::ST_SDID;
      end
      aem_pkg::ST_SDID: begin
        s_d.sdid = in_word[7:0];
        s_d.st   = aem_pkg::ST_DC;
      end
      aem_pkg::ST_DC: begin
        start         = 1'b1;
        // The body count includes the checksum word.
        s_d.body_left = {1'b0, dc} + 9'h001;
        s_d.udw_idx   = 8'h00;
        s_d.st        = aem_pkg::ST_BODY;
      end
      aem_pkg::ST_BODY: begin
        // Only EDH packets feed the flag and CRC-valid registers.
        if (s_q.did == aem_pkg::EDH_DID) begin
          case (s_q.udw_idx)
            aem_pkg::UDW_AP_CRC_HI: s_d.ap_v = in_word[aem_pkg::CRC_V_BIT];
            aem_pkg::UDW_FF_CRC_HI: s_d.ff_v = in_word[aem_pkg::CRC_V_BIT];
            aem_pkg::UDW_ANC_FLAGS:
              s_d.rx_flags[14:10] = in_word[6:aem_pkg::WORD_FLAG_LSB];
            aem_pkg::UDW_AP_FLAGS:
              s_d.rx_flags[4:0] = in_word[6:aem_pkg::WORD_FLAG_LSB];
            aem_pkg::UDW_FF_FLAGS:
              s_d.rx_flags[9:5] = in_word[6:aem_pkg::WORD_FLAG_LSB];
            default: ;
          endcase
        end
        s_d.udw_idx   = s_q.udw_idx + 8'h01;
        s_d.body_left = s_q.body_left - 9'h001;
        if (s_q.body_left == 9'h001) begin
          pkt_end = s_q.did == aem_pkg::EDH_DID;
          s_d.st  = aem_pkg::ST_IDLE;
        end
      end
      default: s_d.st = aem_pkg::ST_IDLE;
    endcase

    // ========================================================================
    // Output side: five-word delay so the strobe can open on the preamble.
    // ========================================================================
    s_d.dly[0] = in_word;
    for (int i = 1; i < aem_pkg::DLY_DEPTH; i++) begin
      s_d.dly[i] = s_q.dly[i-1];
    end
    // The strobe counter spans the preamble through the checksum, 7 + DC words.
    emitting = start || (s_q.cnt != 9'h000);
    last     = !start && (s_q.cnt == 9'h001);
    emit_pos = start ? 9'h000 : s_q.pos;
    // The identifiers were captured two words and one word ago, so the filter verdict is
    // ready as the first preamble word leaves the delay line.
    if (start) begin
      s_d.cnt     = aem_pkg::HDR_WORDS + {1'b0, dc} - 9'h001;
      s_d.aux_sel = !filt_any || filt_hit;
      s_d.ins_on  = (s_q.did == aem_pkg::EDH_DID) && s_q.upd_en;
      s_d.sum     = 9'h000;
    end else if (s_q.cnt != 9'h000) begin
      s_d.cnt = s_q.cnt - 9'h001;
    end
    s_d.pos = emit_pos + 9'h001;

    w = s_q.dly[aem_pkg::DLY_DEPTH-1];
    // With update on, the flag words and checksum of an EDH packet are rewritten;
    // every other word passes unchanged.
    if (emitting && !start && s_q.ins_on) begin
      if (last) begin
        w = {~s_q.sum[8], s_q.sum};
      end else begin
        case (emit_pos)
          aem_pkg::POS_ANC_FLAGS: w = flag_word(upd_now[14:10]);
          aem_pkg::POS_FF_FLAGS:  w = flag_word(upd_now[9:5]);
          aem_pkg::POS_AP_FLAGS:  w = flag_word(upd_now[4:0]);
          default: ;
        endcase
      end
    end

    // The checksum covers DID through the last user word as sent.
    if (emitting && !start && !last && emit_pos >= aem_pkg::POS_DID) begin
      s_d.sum = s_q.sum + w[8:0];
    end
    s_d.out_word = w;
    s_d.aux_out  = emitting && (start ? s_d.aux_sel : s_q.aux_sel);

    // ========================================================================
    // EDH presence and flag lifetime; a packet ending now wins over the clear for present, and for the updated flags with update on.
    // ========================================================================
    if (v_fall) begin
      s_d.seen_vb = 1'b0;
      if (!s_q.seen_vb) begin
        s_d.present   = 1'b0;
        s_d.rx_flags  = '0;
        s_d.upd_flags = aem_pkg::UES_MASK;
        s_d.ap_v      = 1'b0;
        s_d.ff_v      = 1'b0;
      end
    end
    if (pkt_end) begin
      s_d.present = 1'b1;
      if (in_v) begin
        s_d.seen_vb = 1'b1;
      end
      if (s_q.upd_en) begin
        s_d.upd_flags = upd_now;
      end
    end

    // ========================================================================
    // Host register writes.
    // ========================================================================
    // Writes to read-only or unmapped addresses are dropped without notice.
    if (reg_wr) begin
      if (reg_addr == aem_pkg::ADDR_FORMAT) begin
        s_d.upd_en = reg_wdata[aem_pkg::FMT_UPDATE_BIT];
      end
      for (int i = 0; i < aem_pkg::NUM_FILTERS; i++) begin
        if (reg_addr == aem_pkg::ADDR_FILTER_BASE + 8'(i)) begin
          s_d.filt[i] = reg_wdata;
        end
      end
    end

    // ========================================================================
    // Host register reads, reserved bits read zero.
    // ========================================================================
    s_d.rdata = aem_pkg::REG_RESET;
    case (reg_addr)
      aem_pkg::ADDR_RX_FLAGS:  s_d.rdata = {1'b0, s_q.rx_flags};
      aem_pkg::ADDR_UPD_FLAGS: s_d.rdata = {1'b0, s_q.upd_flags};
      aem_pkg::ADDR_FORMAT: begin
        s_d.rdata[aem_pkg::FMT_UPDATE_BIT]   = s_q.upd_en;
        s_d.rdata[aem_pkg::FMT_AP_VALID_BIT] = s_q.ap_v && s_q.present;
        s_d.rdata[aem_pkg::FMT_FF_VALID_BIT] = s_q.ff_v && s_q.present;
        s_d.rdata[aem_pkg::FMT_PRESENT_BIT]  = s_q.present;
      end
      default: begin
        for (int i = 0; i < aem_pkg::NUM_FILTERS; i++) begin
          if (reg_addr == aem_pkg::ADDR_FILTER_BASE + 8'(i)) begin
            s_d.rdata = s_q.filt[i];
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      // Reset clears every filter, so all packets are flagged until one is set.
      s_q    <= '0;
      s_q.st <= aem_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign vid_out            = s_q.out_word;
  assign aux_presence       = s_q.aux_out;
  assign edh_packet_present = s_q.present;

endmodule

/* File: dv/aem_aux_sink.sv */
module aem_aux_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [9:0]  word,
  output logic      [15:0] n_words,
  output logic      [9:0]  last_word
);
  // ==========================================================================
  // Capture
  // ==========================================================================
  // Counts every word that the strobe marks and keeps the last one, standing in for an external memory.
  always_ff @(posedge clk) begin
    if (rst) begin
      n_words   <= 16'h0000;
      last_word <= 10'h000;
    end else if (wr_en) begin
      n_words   <= n_words + 16'h0001;
      last_word <= word;
    end
  end
endmodule

/* File: dv/aem_chk.sv */
module aem_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  rx_word,
  input wire logic        rx_vblank,
  input wire logic [9:0]  fifo_word,
  input wire logic        fifo_vblank,
  input wire logic        fifo_video_mode,
  input wire logic        ap_crc_error,
  input wire logic        ff_crc_error,
  input wire logic        anc_checksum_error,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [9:0]  vid_out,
  input wire logic        aux_presence,
  input wire logic        edh_packet_present
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [9:0] sel;
  logic       vb;
  logic       upd_q;
  logic       lost_q;
  logic [2:0] age_q;
  assign sel = fifo_video_mode ? fifo_word : rx_word;
  assign vb  = fifo_video_mode ? fifo_vblank : rx_vblank;
  // Tracks the update bit and whether the EDH indication has been lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      upd_q  <= 1'b0;
      lost_q <= 1'b0;
      age_q  <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == aem_pkg::ADDR_FORMAT) upd_q <= reg_wdata[11];
      if ($fell(edh_packet_present)) lost_q <= 1'b1;
      else if (edh_packet_present) lost_q <= 1'b0;
      if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> reg_rdata == 16'h0000 && !aux_presence
    && !edh_packet_present) else $error("outputs not clear after reset");
  a_stream_delay: assert property (age_q == 3'h7 && !upd_q && !$past(upd_q, 6)
    |-> vid_out == $past(sel, 6)) else $error("output word not the selected input");
  a_strobe_min: assert property ($rose(aux_presence) |-> aux_presence [*7])
    else $error("strobe shorter than a packet header");
  a_strobe_pre: assert property ($rose(aux_presence) |-> vid_out[9:2] == 8'h00
    ##1 vid_out[9:2] == 8'hFF ##1 vid_out[9:2] == 8'hFF) else $error("strobe not on preamble");
  a_present_drop: assert property ($fell(edh_packet_present) |-> !vb
    && ($past(vb) || $past(vb, 2) || $past(vb, 3))) else $error("EDH drop not at blanking end");
  a_present_read: assert property (reg_addr == aem_pkg::ADDR_FORMAT
    |=> reg_rdata[8] == $past(edh_packet_present)) else $error("present bit mismatch");
  a_crc_mask: assert property (reg_addr == aem_pkg::ADDR_FORMAT && !edh_packet_present
    |=> reg_rdata[10:9] == 2'b00) else $error("CRC valid set without EDH");
  a_fmt_enable: assert property (reg_addr == aem_pkg::ADDR_FORMAT
    |=> reg_rdata[15:11] == {4'h0, $past(upd_q)}) else $error("update bit mismatch");
  a_ues_forced: assert property (lost_q && !edh_packet_present
    && reg_addr == aem_pkg::ADDR_UPD_FLAGS |=> (reg_rdata & 16'h4210) == 16'h4210)
    else $error("unsupported markers not high");
  a_filter_back: assert property (reg_wr && reg_addr inside {[8'h0A:8'h0E]}
    ##1 !reg_wr && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("filter readback mismatch");
  a_unmapped_zero: assert property (!(reg_addr inside {8'h02, 8'h03, 8'h04,
    [8'h0A:8'h0E]}) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  c_strobe: cover property ($rose(aux_presence));
  c_edh_up: cover property ($rose(edh_packet_present));
  c_edh_down: cover property ($fell(edh_packet_present));
endmodule

bind aem_monitor aem_chk i_chk (.clk(clk), .rst(rst), .rx_word(rx_word),
  .rx_vblank(rx_vblank), .fifo_word(fifo_word), .fifo_vblank(fifo_vblank),
  .fifo_video_mode(fifo_video_mode), .ap_crc_error(ap_crc_error),
  .ff_crc_error(ff_crc_error), .anc_checksum_error(anc_checksum_error),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .vid_out(vid_out), .aux_presence(aux_presence), .edh_packet_present(edh_packet_present));

/* File: dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  rx_word = 10'h200, fifo_word = 10'h200, vid_out;
  logic        rx_vblank = 1'b0, fifo_vblank = 1'b0, fifo_video_mode = 1'b0, reg_wr = 1'b0;
  logic        ap_crc_error = 1'b0, ff_crc_error = 1'b0, anc_checksum_error = 1'b0;
  logic        aux_presence, edh_packet_present, probe = 1'b0, probe_q = 1'b0, sel = 1'b0;
  logic        vb = 1'b0;
  logic [2:0]  errs = 3'h0;
  logic [7:0]  reg_addr = 8'h00, body[$];
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, n_words, base = 16'h0000, got, exp_q[$];
  logic [14:0] f1, f2;
  logic [31:0] seed = 32'h0E78233D;
  logic [16:0] tbl [6] = '{17'h14199, 17'h15007, 17'h05008, 17'h16233, 17'h06234, 17'h17070};
  int          n_errors = 0, cmp_count = 0;

  always #50 clk = ~clk;

  aem_monitor i_dut (.clk(clk), .rst(rst), .rx_word(rx_word), .rx_vblank(rx_vblank),
    .fifo_word(fifo_word), .fifo_vblank(fifo_vblank), .fifo_video_mode(fifo_video_mode),
    .ap_crc_error(ap_crc_error), .ff_crc_error(ff_crc_error),
    .anc_checksum_error(anc_checksum_error), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vid_out(vid_out),
    .aux_presence(aux_presence), .edh_packet_present(edh_packet_present));
  aem_aux_sink i_sink (.clk(clk), .rst(rst), .wr_en(aux_presence), .word(vid_out),
    .n_words(n_words), .last_word());

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] rp(input logic [4:0] f, input logic e);
    return {f[4], f[3] | f[2], 1'b0, f[1] | f[0], e};
  endfunction
  // The stream not being parsed carries random words to prove it is ignored.
  task automatic put(input logic [9:0] w);
    @(posedge clk);
    seed = lfsr(seed);
    rx_word <= fifo_video_mode ? seed[9:0] : w;
    fifo_word <= fifo_video_mode ? w : seed[9:0];
    rx_vblank <= vb;
    fifo_vblank <= vb;
    {anc_checksum_error, ap_crc_error, ff_crc_error} <= errs;
  endtask
  task automatic idle(input int n);
    repeat (n) put(10'h200);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e, input logic s);
    @(posedge clk);
    exp_q.push_back(e);
    reg_addr <= a;
    probe <= 1'b1;
    sel <= s;
    @(posedge clk);
    probe <= 1'b0;
  endtask
  task automatic fill(input int n);
    body.delete();
    repeat (n) begin
      seed = lfsr(seed);
      body.push_back(seed[7:0]);
    end
  endtask
  task automatic send(input logic [7:0] did, sdid, input logic ten, input logic flag);
    logic [8:0] sum;
    sum = 9'(did) + 9'(sdid) + 9'(body.size());
    put(10'h000);
    repeat (2) put(ten ? 10'h3FF : 10'h3FC);
    put({2'b10, did});
    put({2'b10, sdid});
    put({2'b10, 8'(body.size())});
    foreach (body[i]) begin
      put({2'b10, body[i]});
      sum = sum + 9'(body[i]);
    end
    put({~sum[8], sum});
    idle(9);
    chk(8'h05, flag ? 16'(7 + body.size()) : 16'h0000, 1'b1);
  endtask
  task automatic edh(input logic [14:0] f, input logic [1:0] v);
    fill(16);
    body[6] = {1'b0, f[14:10], 2'b00};
    body[7] = {1'b0, f[4:0], 2'b00};
    body[8] = {1'b0, f[9:5], 2'b00};
    body[2][7] = v[1];
    body[5][7] = v[0];
    vb = 1'b1;
    idle(2);
    send(aem_pkg::EDH_DID, 8'h02, 1'b1, 1'b1);
    vb = 1'b0;
    idle(3);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Result checker
  // ==========================================================================
  always @(posedge clk) begin
    probe_q <= probe;
    if (probe_q) begin
      got = sel ? n_words - base : reg_rdata;
      cmp_count++;
      if (got !== exp_q[0]) begin
        n_errors++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp_q[0]);
      end
      if (sel) base = n_words;
      void'(exp_q.pop_front());
    end
  end

  initial begin
    #(30000 * 100);
    n_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 2; i <= 14; i++) chk(8'(i), aem_pkg::REG_RESET, 1'b0);
    wr(aem_pkg::ADDR_RX_FLAGS, 16'hFFFF);
    chk(aem_pkg::ADDR_RX_FLAGS, 16'h0000, 1'b0);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      wr(aem_pkg::ADDR_FILTER_BASE + 8'(i), seed[15:0]);
      chk(aem_pkg::ADDR_FILTER_BASE + 8'(i), seed[15:0], 1'b0);
      wr(aem_pkg::ADDR_FILTER_BASE + 8'(i), 16'h0000);
    end
    $display("register test done");
    fill(3);
    send(8'h45, 8'h01, 1'b1, 1'b1);
    fill(0);
    send(8'h61, 8'h02, 1'b0, 1'b1);
    $display("unfiltered test done");
    wr(aem_pkg::ADDR_FILTER_BASE, 16'h4100);
    wr(aem_pkg::ADDR_FILTER_BASE + 8'h01, 16'h5007);
    wr(aem_pkg::ADDR_FILTER_BASE + 8'h03, 16'h0033);
    wr(aem_pkg::ADDR_FILTER_BASE + 8'h04, 16'h7070);
    foreach (tbl[i]) begin
      fill(2);
      send(tbl[i][15:8], tbl[i][7:0], 1'(i), tbl[i][16]);
    end
    $display("filter test done");
    @(posedge clk);
    fifo_video_mode <= 1'b1;
    fill(4);
    send(8'h50, 8'h07, 1'b1, 1'b1);
    fill(1);
    send(8'h62, 8'h34, 1'b0, 1'b0);
    @(posedge clk);
    fifo_video_mode <= 1'b0;
    for (int i = 0; i < 5; i++) wr(aem_pkg::ADDR_FILTER_BASE + 8'(i), 16'h0000);
    $display("fifo mode test done");
    seed = lfsr(seed);
    f1 = seed[14:0];
    edh(f1, 2'b11);
    chk(aem_pkg::ADDR_RX_FLAGS, {1'b0, f1}, 1'b0);
    chk(aem_pkg::ADDR_FORMAT, 16'h0700, 1'b0);
    wr(aem_pkg::ADDR_FORMAT, 16'h0800);
    seed = lfsr(seed);
    f2 = seed[14:0];
    errs = seed[17:15];
    edh(f2, 2'b01);
    chk(aem_pkg::ADDR_RX_FLAGS, {1'b0, f2}, 1'b0);
    chk(aem_pkg::ADDR_UPD_FLAGS, {1'b0, rp(f2[14:10], errs[2]), rp(f2[9:5], errs[0]),
      rp(f2[4:0], errs[1])}, 1'b0);
    chk(aem_pkg::ADDR_FORMAT, 16'h0B00, 1'b0);
    wr(aem_pkg::ADDR_FORMAT, 16'h0000);
    errs = 3'h0;
    vb = 1'b1;
    idle(20);
    vb = 1'b0;
    idle(3);
    chk(aem_pkg::ADDR_RX_FLAGS, 16'h0000, 1'b0);
    chk(aem_pkg::ADDR_UPD_FLAGS, 16'h4210, 1'b0);
    chk(aem_pkg::ADDR_FORMAT, 16'h0000, 1'b0);
    $display("edh test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk(aem_pkg::ADDR_UPD_FLAGS, 16'h0000, 1'b0);
    repeat (3) @(posedge clk);
    $display("second reset test done");
    end_of_test();
  end
endmodule
